// File: ccmg_pkg.sv
// Purpose: Shared constants, types and decode functions for the CPU clock mode generator.
// Assumes: One system clock at 250 MHz; oscillator and port pins are sampled asynchronously.
// Notes: Counts are in system clock cycles, except resync counts in oscillator transitions.
//
// Functional notes
// (RQ1) Both CPU clock edges are usable; each edge-to-edge interval is one phase time.
// (RQ2) Generation mechanism comes from bits 7..5 of the reset port config register.
// (RQ3) Long hardware reset loads that register from the port 0 upper half pins.
// (RQ4) Decode: 111 x4, 110 x3, 101 x2, 100 x5, 011 1:1, 010 x1.5, 001 /2, 000 x2.5.
// (RQ5) Prescaler mode divides the oscillator input by two.
// (RQ6) Prescaler high and low phases each last one full oscillator period.
// (RQ7) Multiplying modes enable the loop; CPU frequency is oscillator times factor.
// (RQ8) Loop resynchronises to the oscillator once every F oscillator transitions; the code uses two transitions for x1.5 and x2.5.
// (RQ9) Resynchronisation is gradual, no abrupt frequency step, staying locked.
// (RQ10) Direct drive disables the loop and passes the oscillator straight through.
// (RQ11) Direct drive phases follow oscillator high/low; two phases equal one period.
// (RQ12) Latched mode stays fixed until the next long hardware reset.

package ccmg_pkg;

    localparam int CLK_FREQ_MHZ = 250;
    localparam int CLK_PERIOD_NS = 4;

    localparam int CFG_W = 8;
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 5;
    localparam int MODE_W = MODE_MSB - MODE_LSB + 1;
    localparam int PER_W = 16;

    // Longest oscillator period; a longest time rounds down
    localparam int OSC_PERIOD_MAX_NS = 500;
    localparam int OSC_PERIOD_MAX_CYC = OSC_PERIOD_MAX_NS / CLK_PERIOD_NS;
    // Twice the longest period without a rising edge means the oscillator stopped
    localparam logic [PER_W-1:0] OSC_TIMEOUT_CYC = PER_W'(2 * OSC_PERIOD_MAX_CYC);
    localparam logic [PER_W-1:0] LOCK_TOL_CYC = 16'h0001;
    localparam logic [PER_W-1:0] PER_ZERO = 16'h0000;

    typedef enum logic [MODE_W-1:0] {
        MODE_MUL2P5 = 3'b000,
        MODE_PRESCALE = 3'b001,
        MODE_MUL1P5 = 3'b010,
        MODE_DIRECT = 3'b011,
        MODE_MUL5 = 3'b100,
        MODE_MUL2 = 3'b101,
        MODE_MUL3 = 3'b110,
        MODE_MUL4 = 3'b111
    } ccmg_mode_e;

    typedef struct packed {
        logic pllEnable;
        logic prescaleActive;
        logic directActive;
        logic locked;
    } ccmg_status_s;

    // CPU phases per oscillator period, twice the factor in multiplying modes; zero for prescaler and direct drive
    function automatic logic [3:0] ccmg_phases_per_osc(input ccmg_mode_e mode);
        case (mode)
            MODE_MUL4: ccmg_phases_per_osc = 4'h8;
            MODE_MUL3: ccmg_phases_per_osc = 4'h6;
            MODE_MUL2: ccmg_phases_per_osc = 4'h4;
            MODE_MUL5: ccmg_phases_per_osc = 4'ha;
            MODE_MUL1P5: ccmg_phases_per_osc = 4'h3;
            MODE_MUL2P5: ccmg_phases_per_osc = 4'h5;
            default: ccmg_phases_per_osc = 4'h0;
        endcase
    endfunction : ccmg_phases_per_osc

    // Oscillator transitions between resync points
    // Half factors resync once per full period: a whole phase count per interval keeps the
    // residue halving from eating toggles
    function automatic logic [3:0] ccmg_resync_transitions(input ccmg_mode_e mode);
        case (mode)
            MODE_MUL4: ccmg_resync_transitions = 4'h4;
            MODE_MUL3: ccmg_resync_transitions = 4'h3;
            MODE_MUL2: ccmg_resync_transitions = 4'h2;
            MODE_MUL5: ccmg_resync_transitions = 4'h5;
            MODE_MUL1P5: ccmg_resync_transitions = 4'h2;
            MODE_MUL2P5: ccmg_resync_transitions = 4'h2;
            default: ccmg_resync_transitions = 4'h1;
        endcase
    endfunction : ccmg_resync_transitions

    function automatic logic ccmg_is_pll(input ccmg_mode_e mode);
        ccmg_is_pll = (mode != MODE_PRESCALE) && (mode != MODE_DIRECT);
    endfunction : ccmg_is_pll

endpackage : ccmg_pkg

// File: ccmg_pin_sync.sv
// Purpose: Two-stage synchroniser for asynchronous pin inputs.
// Assumes: Inputs change independently; no bus coherence is needed.
// Notes: First stage feeds only the second stage.

`timescale 1ns/1ns
`default_nettype none

module ccmg_pin_sync
    import ccmg_pkg::*;
#(
    parameter int WIDTH = 9
) (
    input wire logic clk,
    input wire logic clkEn,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            // No reset, so pin levels are already settled when reset releases
            always_ff @(posedge clk) begin
                if (clkEn) begin
                    stage1_reg[gi] <= asyncIn[gi];
                    stage2_reg[gi] <= stage1_reg[gi];
                end
            end
        end
    endgenerate

    assign syncOut = stage2_reg;

endmodule : ccmg_pin_sync

`default_nettype wire

// File: ccmg_top.sv
// Purpose: Derives the CPU clock from the oscillator by prescaler, direct drive or multiplier.
// Assumes: CPU clock is a sampled digital waveform at system clock resolution.
// Notes: Loop is a digital phase accumulator tracking the measured oscillator period.

`timescale 1ns/1ns
`default_nettype none

module ccmg_top
    import ccmg_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic oscIn,
    input wire logic [CFG_W-1:0] port0UpperHalf,
    output logic cpuClk,
    output logic cpuEdge,
    output logic [PER_W-1:0] clockPhaseTime,
    output logic [MODE_W-1:0] clockModeSelect,
    output logic [CFG_W-1:0] resetPortConfigHigh,
    output ccmg_status_s status
);

    logic [CFG_W:0] pinSync;
    logic oscSync;
    logic [CFG_W-1:0] portSync;

    ccmg_pin_sync #(
        .WIDTH(CFG_W + 1)
    ) u_pin_sync (
        .clk(clk),
        .clkEn(clkEn),
        .asyncIn({oscIn, port0UpperHalf}),
        .syncOut(pinSync)
    );

    assign oscSync = pinSync[CFG_W];
    assign portSync = pinSync[CFG_W-1:0];

    // Configuration latch
    logic [CFG_W-1:0] resetPortConfigHigh_reg;
    ccmg_mode_e mode;

    // Loads while reset is held; pins must be stable for the last edges of reset
    always_ff @(posedge clk) begin
        if (srst) begin
            resetPortConfigHigh_reg <= portSync; // [RQ3]
        end else if (clkEn) begin
            resetPortConfigHigh_reg <= resetPortConfigHigh_reg; // [RQ12]
        end
    end

    assign mode = ccmg_mode_e'(resetPortConfigHigh_reg[MODE_MSB:MODE_LSB]); // [RQ2]

    logic [3:0] phasesPerOsc;
    logic [3:0] resyncCount;
    logic pllMode;

    assign phasesPerOsc = ccmg_phases_per_osc(mode); // [RQ4]
    assign resyncCount = ccmg_resync_transitions(mode); // [RQ4]
    assign pllMode = ccmg_is_pll(mode); // [RQ7]

    // Oscillator edge detection on the synchronised level
    logic oscDly_reg;
    logic oscRise;
    logic oscEdge;

    always_ff @(posedge clk) begin
        if (srst) begin
            // Follow the pin in reset so no false edge appears at release
            oscDly_reg <= oscSync;
        end else if (clkEn) begin
            oscDly_reg <= oscSync;
        end
    end

    assign oscRise = oscSync & ~oscDly_reg;
    assign oscEdge = oscSync ^ oscDly_reg;

    // Oscillator period measurement
    logic [PER_W-1:0] periodCnt_reg;
    logic [PER_W-1:0] measPeriod_reg;
    logic measValid_reg;
    logic measArmed_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            periodCnt_reg <= PER_ZERO;
            measPeriod_reg <= PER_ZERO;
            measValid_reg <= 1'b0;
            measArmed_reg <= 1'b0;
        end else if (clkEn) begin
            if (oscRise) begin
                periodCnt_reg <= PER_ZERO;
                measPeriod_reg <= periodCnt_reg + 16'h0001;
                // First rise after reset closes a partial period, so it only arms
                measValid_reg <= measArmed_reg && (periodCnt_reg < OSC_TIMEOUT_CYC);
                measArmed_reg <= 1'b1;
            end else if (periodCnt_reg >= OSC_TIMEOUT_CYC) begin
                // Stopped oscillator drops the measurement rather than wrapping
                measValid_reg <= 1'b0;
            end else begin
                periodCnt_reg <= periodCnt_reg + 16'h0001;
            end
        end
    end

    // Resync point every F oscillator transitions, every two for the half factors
    logic [3:0] transCnt_reg;
    logic resyncPoint;

    assign resyncPoint = pllMode && oscEdge && (transCnt_reg == (resyncCount - 4'h1)); // [RQ8]

    always_ff @(posedge clk) begin
        if (srst) begin
            transCnt_reg <= 4'h0;
        end else if (clkEn) begin
            if (resyncPoint) begin
                transCnt_reg <= 4'h0; // [RQ8]
            end else if (oscEdge && pllMode) begin
                transCnt_reg <= transCnt_reg + 4'h1;
            end
        end
    end

    // Tracked period takes the first measurement whole, then moves half the error per resync
    logic [PER_W-1:0] pllPeriod_reg;
    logic signed [PER_W:0] periodErr;
    logic signed [PER_W:0] periodStep;

    assign periodErr = $signed({1'b0, measPeriod_reg}) - $signed({1'b0, pllPeriod_reg});
    assign periodStep = periodErr >>> 1;

    always_ff @(posedge clk) begin
        if (srst) begin
            pllPeriod_reg <= PER_ZERO;
        end else if (clkEn) begin
            if (!measValid_reg) begin
                pllPeriod_reg <= PER_ZERO;
            end else if (resyncPoint) begin
                if (pllPeriod_reg == PER_ZERO) begin
                    pllPeriod_reg <= measPeriod_reg;
                end else begin
                    // Gradual correction avoids a frequency step
                    pllPeriod_reg <= PER_W'(pllPeriod_reg + PER_W'(periodStep)); // [RQ9]
                end
            end
        end
    end

    // Phase accumulator: phasesPerOsc toggles per tracked period
    logic [PER_W-1:0] acc_reg;
    logic [PER_W-1:0] accSum;
    logic [PER_W-1:0] accWrap;
    logic pllToggle;
    logic pllRun;

    assign pllRun = pllMode && (pllPeriod_reg != PER_ZERO); // [RQ7]
    assign accSum = acc_reg + {12'h000, phasesPerOsc};
    assign pllToggle = pllRun && (accSum >= pllPeriod_reg); // [RQ7]
    assign accWrap = pllToggle ? (accSum - pllPeriod_reg) : accSum;

    always_ff @(posedge clk) begin
        if (srst) begin
            acc_reg <= PER_ZERO;
        end else if (clkEn) begin
            if (!pllRun) begin
                acc_reg <= PER_ZERO;
            end else if (resyncPoint) begin
                // Halving the residue pulls the phase toward the oscillator edge
                acc_reg <= accWrap >> 1; // [RQ8] [RQ9]
            end else begin
                acc_reg <= accWrap;
            end
        end
    end

    // CPU clock selection
    logic cpuClk_reg;
    logic cpuClkNext;

    always_comb begin
        cpuClkNext = cpuClk_reg;
        case (mode)
            MODE_PRESCALE: begin
                // Toggle on rising edges only: each phase is one oscillator period
                if (oscRise) begin
                    cpuClkNext = ~cpuClk_reg; // [RQ5] [RQ6]
                end
            end
            MODE_DIRECT: begin
                cpuClkNext = oscSync; // [RQ10] [RQ11]
            end
            default: begin
                if (!pllRun) begin
                    cpuClkNext = 1'b0;
                end else if (pllToggle) begin
                    cpuClkNext = ~cpuClk_reg; // [RQ7]
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cpuClk_reg <= 1'b0;
        end else if (clkEn) begin
            cpuClk_reg <= cpuClkNext;
        end
    end

    // Edge strobe and phase length measurement
    logic cpuEdge_reg;
    logic [PER_W-1:0] phaseCnt_reg;
    logic [PER_W-1:0] clockPhaseTime_reg;
    logic cpuEdgeNow;

    assign cpuEdgeNow = (cpuClkNext != cpuClk_reg); // [RQ1]

    always_ff @(posedge clk) begin
        if (srst) begin
            cpuEdge_reg <= 1'b0;
            phaseCnt_reg <= PER_ZERO;
            clockPhaseTime_reg <= PER_ZERO;
        end else if (clkEn) begin
            cpuEdge_reg <= cpuEdgeNow; // [RQ1]
            if (cpuEdgeNow) begin
                phaseCnt_reg <= PER_ZERO;
                clockPhaseTime_reg <= phaseCnt_reg + 16'h0001; // [RQ1]
            end else if (phaseCnt_reg != 16'hffff) begin
                phaseCnt_reg <= phaseCnt_reg + 16'h0001;
            end
        end
    end

    // Status
    ccmg_status_s status_reg;
    logic [PER_W-1:0] errMag;

    assign errMag = periodErr[PER_W] ? PER_W'(-periodErr) : PER_W'(periodErr);

    always_ff @(posedge clk) begin
        if (srst) begin
            status_reg <= '0;
        end else if (clkEn) begin
            status_reg.pllEnable <= pllMode; // [RQ7] [RQ10]
            status_reg.prescaleActive <= (mode == MODE_PRESCALE);
            status_reg.directActive <= (mode == MODE_DIRECT);
            status_reg.locked <= pllRun && measValid_reg && (errMag <= LOCK_TOL_CYC); // [RQ9]
        end
    end

    assign cpuClk = cpuClk_reg;
    assign cpuEdge = cpuEdge_reg;
    assign clockPhaseTime = clockPhaseTime_reg;
    assign resetPortConfigHigh = resetPortConfigHigh_reg;
    assign clockModeSelect = resetPortConfigHigh_reg[MODE_MSB:MODE_LSB];
    assign status = status_reg;

endmodule : ccmg_top

`default_nettype wire

// File: ccmg_top_properties.sv
// Purpose: Port-level assertions for ccmg_top.
// Assumes: clkEn held high by the bench.
// Notes: runCnt masks pipeline fill after reset.
`timescale 1ns/1ns
`default_nettype none
module ccmg_top_properties
    import ccmg_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic oscIn,
    input wire logic [CFG_W-1:0] port0UpperHalf,
    input wire logic cpuClk,
    input wire logic cpuEdge,
    input wire logic [PER_W-1:0] clockPhaseTime,
    input wire logic [MODE_W-1:0] clockModeSelect,
    input wire logic [CFG_W-1:0] resetPortConfigHigh,
    input wire ccmg_status_s status
);
    logic [3:0] runCnt;
    logic warm;
    always_ff @(posedge clk) begin
        if (srst) begin
            runCnt <= 4'h0;
        end else if (runCnt != 4'hf) begin
            runCnt <= runCnt + 4'h1;
        end
    end
    // Sync pipeline still holds reset-time levels early on
    assign warm = (runCnt > 4'h5);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_config_frozen: assert property (runCnt != 4'h0 |-> $stable(resetPortConfigHigh))
        else $error("config changed outside reset");
    a_mode_field: assert property (clockModeSelect == resetPortConfigHigh[MODE_MSB:MODE_LSB])
        else $error("mode field not config bits 7..5");
    a_edge_pulse: assert property (runCnt != 4'h0 |-> cpuEdge == (cpuClk != $past(cpuClk)))
        else $error("cpuEdge not aligned with cpuClk change");
    a_direct_follow: assert property (warm && status.directActive |-> cpuClk == $past(oscIn, 3))
        else $error("direct clock not following oscillator");
    a_prescale_edge: assert property (warm && status.prescaleActive && $rose(oscIn) |-> ##3 cpuEdge)
        else $error("prescaler missed oscillator rise");
    a_status_decode: assert property (warm |-> status.directActive == (clockModeSelect == 3'h3)
        && status.prescaleActive == (clockModeSelect == 3'h1))
        else $error("status does not match mode");
    a_pll_enable: assert property (warm |-> status.pllEnable
        == (clockModeSelect != 3'h3 && clockModeSelect != 3'h1))
        else $error("loop enable does not match mode");
    a_phase_stands: assert property (warm && $changed(clockPhaseTime) |-> cpuEdge || $past(cpuEdge))
        else $error("phase time changed away from an edge");
    c_direct: cover property (status.directActive && cpuEdge);
    c_prescale: cover property (status.prescaleActive && cpuEdge);
    c_pll_lock: cover property (status.pllEnable && status.locked && cpuEdge);
endmodule : ccmg_top_properties
bind ccmg_top ccmg_top_properties u_props (.clk(clk), .srst(srst), .clkEn(clkEn),
    .oscIn(oscIn), .port0UpperHalf(port0UpperHalf), .cpuClk(cpuClk), .cpuEdge(cpuEdge),
    .clockPhaseTime(clockPhaseTime), .clockModeSelect(clockModeSelect),
    .resetPortConfigHigh(resetPortConfigHigh), .status(status));
`default_nettype wire

// File: ccmg_osc_model.sv
// Purpose: External oscillator driving the clock pin.
// Assumes: High and low times in ns, read each half period.
// Notes: Starts 1 ns off the system edge to avoid races.
`timescale 1ns/1ns
`default_nettype none
module ccmg_osc_model (
    input var int highNs,
    input var int lowNs,
    output logic osc
);
    // Free running, as a real oscillator never pauses
    initial begin
        osc = 1'b0;
        #1;
        forever begin
            osc = 1'b1;
            #(highNs);
            osc = 1'b0;
            #(lowNs);
        end
    end
endmodule : ccmg_osc_model
`default_nettype wire

// File: ccmg_top_test.sv
// Purpose: Self-checking bench for ccmg_top over all eight modes.
// Assumes: Oscillator period 40 clk cycles; clkEn tied high.
// Notes: Edge counts allow small window jitter.
`timescale 1ns/1ns
`default_nettype none
module ccmg_top_test;
    import ccmg_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic clkEn = 1'b1;
    logic oscIn;
    logic [7:0] pins = 8'hff;
    logic cpuClk, cpuEdge;
    logic [15:0] clockPhaseTime;
    logic [2:0] clockModeSelect;
    logic [7:0] resetPortConfigHigh;
    ccmg_status_s status;
    int highNs = 80;
    int lowNs = 80;
    int n_errors = 0;
    int n_compared = 0;
    logic [16:0] seed = 17'h13758;
    ccmg_osc_model osc (.highNs(highNs), .lowNs(lowNs), .osc(oscIn));
    ccmg_top uut (.clk(clk), .srst(srst), .clkEn(clkEn), .oscIn(oscIn),
        .port0UpperHalf(pins), .cpuClk(cpuClk), .cpuEdge(cpuEdge),
        .clockPhaseTime(clockPhaseTime), .clockModeSelect(clockModeSelect),
        .resetPortConfigHigh(resetPortConfigHigh), .status(status));
    initial begin
        forever #2 clk = ~clk;
    end
    // Edges per eight oscillator periods, twice the factor each
    function automatic int exp_edges(input logic [2:0] m);
        case (m)
            3'h7: return 64;
            3'h6: return 48;
            3'h5: return 32;
            3'h4: return 80;
            3'h3: return 16;
            3'h2: return 24;
            3'h1: return 8;
            default: return 40;
        endcase
    endfunction : exp_edges
    function automatic logic [16:0] lfsr_next(input logic [16:0] v);
        return {v[15:0], v[16] ^ v[13]};
    endfunction : lfsr_next
    task automatic check(input string what, input logic [15:0] e, input logic [15:0] s);
        n_compared++;
        if (s !== e) begin
            $display("unexpected %s expected %h seen %h", what, e, s);
            n_errors++;
        end
    endtask : check
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic wait_edge;
        int i;
        for (i = 0; i < 400; i++) begin
            tick(1);
            if (cpuEdge === 1'b1) break;
        end
        if (i == 400) begin
            check("cpuEdge wait", 16'h1, 16'h0);
            stop_test();
        end else begin
            tick(2);
        end
    endtask : wait_edge
    task automatic run_mode(input logic [2:0] m);
        logic [7:0] latched;
        logic [15:0] t1;
        int cnt;
        int e;
        latched = {m, seed[4:0]};
        seed = lfsr_next(seed);
        pins = latched;
        // Uneven duty only matters in direct drive
        highNs = (m == 3'h3) ? 48 : 80;
        lowNs = (m == 3'h3) ? 112 : 80;
        srst = 1'b1;
        tick(8);
        srst = 1'b0;
        check("config", {8'h0, latched}, {8'h0, resetPortConfigHigh});
        check("mode", {13'h0, m}, {13'h0, clockModeSelect});
        pins = ~latched;
        tick(10);
        check("config held", {8'h0, latched}, {8'h0, resetPortConfigHigh});
        tick(800);
        check("status", {13'h0, m != 3'h3 && m != 3'h1, m == 3'h1, m == 3'h3},
            {13'h0, status[3:1]});
        if (m != 3'h3 && m != 3'h1) begin
            check("locked", 16'h1, {15'h0, status.locked});
        end
        cnt = 0;
        for (int i = 0; i < 320; i++) begin
            tick(1);
            if (cpuEdge === 1'b1) cnt++;
        end
        e = exp_edges(m);
        n_compared++;
        if (cnt < e - 2 || cnt > e + 2) begin
            $display("unexpected cpuEdge count expected %0d seen %0d", e, cnt);
            n_errors++;
        end
        wait_edge();
        t1 = clockPhaseTime;
        if (m == 3'h1) begin
            check("prescale phase", 16'd40, t1);
        end
        wait_edge();
        if (m == 3'h3) begin
            check("direct phase pair", 16'd40, t1 + clockPhaseTime);
        end
        $display("mode %0d done", m);
    endtask : run_mode
    initial begin
        tick(8);
        for (int m = 7; m >= 0; m--) begin
            run_mode(3'(m));
        end
        stop_test();
    end
endmodule : ccmg_top_test
`default_nettype wire
